// >>> src/ipb_map.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  host bus port. Definitions only; included by the host port module alone.
*/
`ifndef IPB_MAP_SVH
`define IPB_MAP_SVH

// Configuration register indexes
`define IPB_REG_RD_PORT 8'h00
`define IPB_REG_CFG_CTRL 8'h02
`define IPB_REG_WAKE 8'h03
`define IPB_REG_CSN 8'h06
`define IPB_REG_ACTIVATE 8'h30
`define IPB_REG_RANGE 8'h31
`define IPB_REG_BASE_HI 8'h60
`define IPB_REG_BASE_LO 8'h61
`define IPB_REG_IRQ_SEL 8'h70
`define IPB_REG_IRQ_TYPE 8'h71
`define IPB_REG_DMA0 8'h74
`define IPB_REG_DMA1 8'h75

// Field positions
`define IPB_ACT_EN_BIT 0
`define IPB_RC_EN_BIT 1
`define IPB_RC_PAT_BIT 0
`define IPB_CC_RESET_BIT 0
`define IPB_CC_WAIT_BIT 1
`define IPB_CC_CSN0_BIT 2

// Fixed read values
`define IPB_UNIMPL_VAL 8'h00
`define IPB_DMA_NONE_VAL 8'h04
`define IPB_PAT_SET 8'h55
`define IPB_PAT_CLR 8'hAA

// Configuration port addresses and ISA-PC window root
`define IPB_PNP_ADDR_PORT 12'h279
`define IPB_PNP_WDATA_PORT 12'hA79
`define IPB_ISA_BASE_ROOT 10'h200

// Reset values
`define IPB_CFG_RST 8'h00
`define IPB_SYNC_RST 13'h003F

// Timing
`define IPB_CLK_NS 50
`define IPB_AUX_PERIOD_US 125
`define IPB_AUX_CYCLES ((`IPB_AUX_PERIOD_US * 1000) / `IPB_CLK_NS)
`define IPB_INIT_CAPTURE 3'h5
`define IPB_INIT_DONE 3'h6

`endif

// >>> src/ipb_pkg.sv
/*
  Types of the host bus port: bus mode and configuration state.
  Needs nothing from ipb_map.svh; the enum encodings are written here.
*/
package ipb_pkg;

  typedef enum logic [1:0] {
    MODE_ISA = 2'h0,
    MODE_PNP = 2'h1,
    MODE_PROC = 2'h3
  } ipb_mode_e;

  typedef enum logic [1:0] {
    ST_WAIT = 2'h0,
    ST_SLEEP = 2'h1,
    ST_ISOL = 2'h3,
    ST_CFG = 2'h2
  } ipb_pnp_state_e;

endpackage : ipb_pkg

// >>> src/ipb_sync3.sv
/*
  Three-stage synchroniser with agreement filter for pin inputs.
  Assumes all bits are independent levels; q changes once stages two and three agree.
*/
`timescale 1ns/1ps
module ipb_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= RST;
      s2 <= RST;
      s3 <= RST;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Per bit: a lone glitch in stage two never reaches q
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST;
    end else begin
      q <= (s2 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
    end
  end
endmodule : ipb_sync3

// >>> src/ipb_tick.sv
/*
  Periodic one-cycle tick generator.
  Assumes en is synchronous to ref_clk; the count restarts whenever en is low.
*/
`timescale 1ns/1ps
module ipb_tick #(
  parameter int unsigned PERIOD = 2500
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic en,
  output logic tick
);
  logic [11:0] cnt;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 12'h000;
      tick <= 1'b0;
    end else if (!en) begin
      cnt <= 12'h000;
      tick <= 1'b0;
    end else if (cnt == 12'(PERIOD - 1)) begin
      cnt <= 12'h000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 12'h001;
      tick <= 1'b0;
    end
  end

  property p_tick_spacing;
    @(posedge ref_clk) disable iff (!rst_n)
    tick |=> !tick [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick repeated too soon");
endmodule : ipb_tick

// >>> src/ipb_host_port.sv
/*
  Host bus front end: ISA-PC, Plug and Play and processor-mode decoding,
  configuration registers and the auxiliary transfer request.
  Assumes a register core that answers core_rdata combinationally in the
  cycle core_rd is high, and bus pins asynchronous to ref_clk.
*/
// Summary of operation
// - Last isolated card waits for its number
// - Inactive card answers configuration ports and range check reads only
// - Reset clears activate; upper bits read zero
// - Range check enable bit, only while inactive
// - Range check reads return 55h or AAh
// - Base address held in two bytes
// - Plug and Play compares address bits 11:0
// - IRQ select low nibble picks line
// - IRQ type writable, no effect
// - Unimplemented read 00h, DMA registers 04h
// - Ten or twelve address bits, two ports
// - Address enable low, one strobe, SA0 selects
// - Never masters the bus
// - Direction output low only while read
// - Open mode pin, low straps: processor mode
// - Processor modes 2, 3 with chip select
// - Mode 4 latch pulse captures address
// - Aux request every 125 us, ack clears
// - Matching wake number enters configuration state
// - Ack inverts strobes, ignores address
`timescale 1ns/1ps
`include "ipb_map.svh"
module ipb_host_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Host bus
  input wire logic [11:0] sa,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic aen_n,
  input wire logic cs_n,
  input wire logic ale,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic buffer_direction_out,
  // Straps
  input wire logic mode_open,
  input wire logic mode_level,
  input wire logic [3:0] io_window_straps,
  // Aux transfer
  input wire logic [1:0] aux_transfer_ack_n,
  output logic aux_transfer_request,
  // Plug and Play
  input wire logic pnp_key_seen,
  output logic cfg_active,
  output logic [3:0] cfg_irq_line,
  // Core register port
  output logic [7:0] core_addr,
  output logic [7:0] core_wdata,
  output logic core_wr,
  output logic core_rd,
  output logic core_ctrl,
  output logic core_aux,
  input wire logic [7:0] core_rdata
);
  logic [12:0] flt;
  logic [19:0] bus_q;
  logic mode_open_f, mode_level_f, ale_f, cs_f, aen_f, ior_f, iow_f;
  logic [3:0] straps_f;
  logic [1:0] ack_f;
  logic [2:0] init_cnt;
  logic ready;
  ipb_pkg::ipb_mode_e bus_mode;
  ipb_pkg::ipb_pnp_state_e pnp_state;
  logic proc_m2;
  logic ale_d, lat_seen;
  logic [7:0] lat_addr;
  logic [11:0] sa_q;
  logic [7:0] din_q;
  logic [7:0] csn, rdp, pnp_index, base_hi, base_lo;
  logic [1:0] range_ck, irq_type;
  logic aux_tick;
  logic acc_prev, rd_core_pend;

  ipb_sync3 #(.W(13), .RST(`IPB_SYNC_RST)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({mode_open, mode_level, io_window_straps, ale, cs_n, aen_n, ior_n, iow_n,
        aux_transfer_ack_n}),
    .q(flt)
  );
  assign {mode_open_f, mode_level_f, straps_f, ale_f, cs_f, aen_f, ior_f, iow_f, ack_f} = flt;

  // Same filter as the strobes; address and data lead the strobe, so settle first
  ipb_sync3 #(.W(20), .RST(20'h0_0000)) u_sync_bus (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({sa, data_in}),
    .q(bus_q)
  );
  assign {sa_q, din_q} = bus_q;

  // Straps are caught once the filter has settled after reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt <= 3'h0;
    end else if (init_cnt != `IPB_INIT_DONE) begin
      init_cnt <= init_cnt + 3'h1;
    end
  end
  assign ready = (init_cnt == `IPB_INIT_DONE);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_mode <= ipb_pkg::MODE_ISA;
      proc_m2 <= 1'b0;
    end else if (init_cnt == `IPB_INIT_CAPTURE) begin
      if (mode_open_f && straps_f == 4'h0) begin
        bus_mode <= ipb_pkg::MODE_PROC;
      end else if (mode_level_f) begin
        bus_mode <= ipb_pkg::MODE_PNP;
      end else begin
        bus_mode <= ipb_pkg::MODE_ISA;
      end
      proc_m2 <= ale_f;
    end
  end

  // Mode 4: a high pulse on the latch captures the address
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ale_d <= 1'b0;
      lat_seen <= 1'b0;
      lat_addr <= 8'h00;
    end else begin
      ale_d <= ale_f;
      if (ready && bus_mode == ipb_pkg::MODE_PROC && !proc_m2 && ale_f && !ale_d) begin
        lat_seen <= 1'b1;
        lat_addr <= sa_q[7:0];
      end
    end
  end

  // Access decode
  logic one_strobe, is_pnp, is_proc, dma_on, range_on;
  logic ap_hit, wp_hit, rp_hit, dev_hit, isa_cyc, isa_rd, isa_acc;
  logic proc_cyc, proc_rd_raw, proc_acc, proc_rd;
  logic acc_now, acc_start, acc_rd;
  logic [11:0] base12;
  logic [9:0] isa_base;

  assign one_strobe = ior_f ^ iow_f;
  assign is_pnp = (bus_mode == ipb_pkg::MODE_PNP);
  assign is_proc = (bus_mode == ipb_pkg::MODE_PROC);
  assign base12 = {base_hi[3:0], base_lo};
  assign isa_base = `IPB_ISA_BASE_ROOT | {2'b00, straps_f, 4'h0};
  assign range_on = range_ck[`IPB_RC_EN_BIT] && !cfg_active;
  assign isa_cyc = !aen_f && one_strobe;
  assign isa_rd = !ior_f;
  assign ap_hit = is_pnp && sa_q == `IPB_PNP_ADDR_PORT && !isa_rd;
  assign wp_hit = is_pnp && sa_q == `IPB_PNP_WDATA_PORT && !isa_rd;
  assign rp_hit = is_pnp && sa_q == {2'b00, rdp, 2'b11} && isa_rd
                  && pnp_state == ipb_pkg::ST_CFG;
  // Two ports: bit 0 is left out of the compare
  assign dev_hit = is_pnp ? (sa_q[11:1] == base12[11:1])
                          : (sa_q[9:1] == isa_base[9:1]);
  assign isa_acc = isa_cyc && (ap_hit || wp_hit || rp_hit
                   || (dev_hit && (!is_pnp || cfg_active || (range_on && isa_rd))));
  assign dma_on = (ack_f != 2'b11);
  assign proc_cyc = proc_m2 ? !ior_f : one_strobe;
  assign proc_rd_raw = proc_m2 ? iow_f : !ior_f;
  assign proc_acc = proc_cyc && (dma_on || !cs_f);
  assign proc_rd = dma_on ? !proc_rd_raw : proc_rd_raw;
  assign acc_now = ready && (is_proc ? proc_acc : isa_acc);
  assign acc_rd = is_proc ? proc_rd : isa_rd;
  assign acc_start = acc_now && !acc_prev;

  logic pnp_wr, range_rd, core_go;
  assign pnp_wr = acc_start && !is_proc && wp_hit;
  assign range_rd = acc_start && !is_proc && dev_hit && !ap_hit && !wp_hit && !rp_hit
                    && is_pnp && !cfg_active;
  assign core_go = acc_start && (is_proc || (dev_hit && !ap_hit && !wp_hit && !rp_hit
                   && (!is_pnp || cfg_active)));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_prev <= 1'b0;
    end else begin
      acc_prev <= acc_now;
    end
  end

  // Core register port
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_addr <= 8'h00;
      core_wdata <= 8'h00;
      core_wr <= 1'b0;
      core_rd <= 1'b0;
      core_ctrl <= 1'b0;
      core_aux <= 1'b0;
    end else begin
      core_wr <= core_go && !acc_rd;
      core_rd <= core_go && acc_rd;
      if (core_go) begin
        core_wdata <= din_q;
        core_aux <= is_proc && dma_on;
        core_ctrl <= !is_proc && sa_q[0];
        if (is_proc && dma_on) begin
          core_addr <= 8'h00;
        end else if (is_proc) begin
          core_addr <= lat_seen ? lat_addr : sa_q[7:0];
        end else begin
          core_addr <= {7'h00, sa_q[0]};
        end
      end
    end
  end

  // Configuration read mux
  logic [7:0] pnp_rdata;
  always_comb begin
    case (pnp_index)
      `IPB_REG_RD_PORT: pnp_rdata = rdp;
      `IPB_REG_CSN: pnp_rdata = csn;
      `IPB_REG_ACTIVATE: pnp_rdata = {7'h00, cfg_active};
      `IPB_REG_RANGE: pnp_rdata = {6'h00, range_ck};
      `IPB_REG_BASE_HI: pnp_rdata = base_hi;
      `IPB_REG_BASE_LO: pnp_rdata = base_lo;
      `IPB_REG_IRQ_SEL: pnp_rdata = {4'h0, cfg_irq_line};
      `IPB_REG_IRQ_TYPE: pnp_rdata = {6'h00, irq_type};
      `IPB_REG_DMA0: pnp_rdata = `IPB_DMA_NONE_VAL;
      `IPB_REG_DMA1: pnp_rdata = `IPB_DMA_NONE_VAL;
      default: pnp_rdata = `IPB_UNIMPL_VAL;
    endcase
  end

  // Read data and buffer direction; the port only answers, it never starts a cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
      buffer_direction_out <= 1'b1;
      rd_core_pend <= 1'b0;
    end else begin
      data_oe <= acc_now && acc_rd;
      buffer_direction_out <= !(acc_now && acc_rd);
      rd_core_pend <= core_go && acc_rd;
      if (rd_core_pend) begin
        data_out <= core_rdata;
      end else if (range_rd) begin
        data_out <= range_ck[`IPB_RC_PAT_BIT] ? `IPB_PAT_SET : `IPB_PAT_CLR;
      end else if (acc_start && rp_hit) begin
        data_out <= pnp_rdata;
      end
    end
  end

  // Configuration index and state
  logic cfg_wr;
  assign cfg_wr = pnp_wr && pnp_state == ipb_pkg::ST_CFG;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pnp_index <= 8'h00;
    end else if (acc_start && !is_proc && ap_hit) begin
      pnp_index <= din_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pnp_state <= ipb_pkg::ST_WAIT;
    end else begin
      case (pnp_state)
        ipb_pkg::ST_WAIT: begin
          if (is_pnp && pnp_key_seen) begin
            pnp_state <= ipb_pkg::ST_SLEEP;
          end
        end
        ipb_pkg::ST_SLEEP: begin
          if (pnp_wr && pnp_index == `IPB_REG_WAKE) begin
            if (din_q == 8'h00 && csn == 8'h00) begin
              pnp_state <= ipb_pkg::ST_ISOL;
            end else if (din_q != 8'h00 && din_q == csn) begin
              pnp_state <= ipb_pkg::ST_CFG;
            end
          end
        end
        ipb_pkg::ST_ISOL: begin
          if (pnp_wr && pnp_index == `IPB_REG_CSN && din_q != 8'h00) begin
            pnp_state <= ipb_pkg::ST_CFG;
          end else if (pnp_wr && pnp_index == `IPB_REG_WAKE && din_q != 8'h00) begin
            pnp_state <= ipb_pkg::ST_SLEEP;
          end
        end
        ipb_pkg::ST_CFG: begin
          if (pnp_wr && pnp_index == `IPB_REG_WAKE && din_q == 8'h00) begin
            pnp_state <= ipb_pkg::ST_SLEEP;
          end else if (cfg_wr && pnp_index == `IPB_REG_CFG_CTRL
                       && din_q[`IPB_CC_WAIT_BIT]) begin
            pnp_state <= ipb_pkg::ST_WAIT;
          end
        end
        default: pnp_state <= ipb_pkg::ST_WAIT;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      csn <= `IPB_CFG_RST;
      rdp <= `IPB_CFG_RST;
    end else begin
      if (pnp_wr && pnp_index == `IPB_REG_CSN
          && (pnp_state == ipb_pkg::ST_ISOL || pnp_state == ipb_pkg::ST_CFG)) begin
        csn <= din_q;
      end else if (pnp_wr && pnp_index == `IPB_REG_CFG_CTRL
                   && din_q[`IPB_CC_CSN0_BIT]) begin
        csn <= 8'h00;
      end
      if (pnp_wr && pnp_index == `IPB_REG_RD_PORT
          && (pnp_state == ipb_pkg::ST_ISOL || pnp_state == ipb_pkg::ST_CFG)) begin
        rdp <= din_q;
      end
    end
  end

  // Logical device registers; only reachable in configuration state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_active <= 1'b0;
      range_ck <= 2'h0;
      base_hi <= `IPB_CFG_RST;
      base_lo <= `IPB_CFG_RST;
      cfg_irq_line <= 4'h0;
      irq_type <= 2'h0;
    end else if (cfg_wr && pnp_index == `IPB_REG_CFG_CTRL && din_q[`IPB_CC_RESET_BIT]) begin
      cfg_active <= 1'b0;
      range_ck <= 2'h0;
      base_hi <= `IPB_CFG_RST;
      base_lo <= `IPB_CFG_RST;
      cfg_irq_line <= 4'h0;
      irq_type <= 2'h0;
    end else if (cfg_wr) begin
      case (pnp_index)
        `IPB_REG_ACTIVATE: cfg_active <= din_q[`IPB_ACT_EN_BIT];
        `IPB_REG_RANGE: range_ck <= din_q[1:0];
        `IPB_REG_BASE_HI: base_hi <= din_q;
        `IPB_REG_BASE_LO: base_lo <= din_q;
        `IPB_REG_IRQ_SEL: cfg_irq_line <= din_q[3:0];
        `IPB_REG_IRQ_TYPE: irq_type <= din_q[1:0];
        default: cfg_active <= cfg_active;
      endcase
    end
  end

  // Aux request: a new period wins over a clearing acknowledge
  ipb_tick #(.PERIOD(`IPB_AUX_CYCLES)) u_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .en(ready && is_proc),
    .tick(aux_tick)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_transfer_request <= 1'b0;
    end else if (aux_tick) begin
      aux_transfer_request <= 1'b1;
    end else if (dma_on) begin
      aux_transfer_request <= 1'b0;
    end
  end

  property p_act_gate;
    @(posedge ref_clk) disable iff (!rst_n)
    (core_wr || core_rd) && is_pnp |-> $past(cfg_active);
  endproperty
  a_act_gate: assert property (p_act_gate) else $error("inactive card reached core");

  property p_act_rsv;
    @(posedge ref_clk) disable iff (!rst_n)
    pnp_index == `IPB_REG_ACTIVATE |-> pnp_rdata[7:1] == 7'h00;
  endproperty
  a_act_rsv: assert property (p_act_rsv) else $error("activate upper bits nonzero");

  property p_range_pat;
    @(posedge ref_clk) disable iff (!rst_n)
    range_rd |=> data_oe && data_out == (range_ck[0] ? 8'h55 : 8'hAA);
  endproperty
  a_range_pat: assert property (p_range_pat) else $error("range pattern wrong");

  property p_dma_val;
    @(posedge ref_clk) disable iff (!rst_n)
    pnp_index == `IPB_REG_DMA0 || pnp_index == `IPB_REG_DMA1 |-> pnp_rdata == 8'h04;
  endproperty
  a_dma_val: assert property (p_dma_val) else $error("dma register not 04h");

  property p_aux_set;
    @(posedge ref_clk) disable iff (!rst_n)
    aux_tick |=> aux_transfer_request;
  endproperty
  a_aux_set: assert property (p_aux_set) else $error("aux request not raised");

  property p_aux_clr;
    @(posedge ref_clk) disable iff (!rst_n)
    dma_on && !aux_tick |=> !aux_transfer_request;
  endproperty
  a_aux_clr: assert property (p_aux_clr) else $error("aux request not dropped");

  property p_dir;
    @(posedge ref_clk) disable iff (!rst_n)
    data_oe |-> !buffer_direction_out ##1 (data_oe || buffer_direction_out);
  endproperty
  a_dir: assert property (p_dir) else $error("direction output disagrees");

  property p_isol_cfg;
    @(posedge ref_clk) disable iff (!rst_n)
    pnp_state == ipb_pkg::ST_ISOL && pnp_wr && pnp_index == `IPB_REG_CSN && din_q != 8'h00
    |=> pnp_state == ipb_pkg::ST_CFG && csn == $past(din_q);
  endproperty
  a_isol_cfg: assert property (p_isol_cfg) else $error("isolation did not end");

  property p_cfg_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    pnp_wr && pnp_state != ipb_pkg::ST_CFG && pnp_index == `IPB_REG_ACTIVATE
    |=> $stable(cfg_active);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("write outside config took");

  property p_dma_aux;
    @(posedge ref_clk) disable iff (!rst_n)
    core_go && is_proc && dma_on |=> core_aux && core_addr == 8'h00;
  endproperty
  a_dma_aux: assert property (p_dma_aux) else $error("dma access not on aux");

  c_core_write: cover property (@(posedge ref_clk) disable iff (!rst_n) core_wr && !core_aux);
  c_range_read: cover property (@(posedge ref_clk) disable iff (!rst_n) range_rd);
  c_cfg_entry: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(pnp_state == ipb_pkg::ST_CFG));
  c_dma_read: cover property (@(posedge ref_clk) disable iff (!rst_n) core_rd && core_aux);
endmodule : ipb_host_port

// >>> verification/ipb_host_model.sv
/*
  Host bus master model: address, strobes, address enable and chip select.
  Assumes one caller at a time; each access starts after a falling edge.
*/
`timescale 1ns/1ps
module ipb_host_model (
  // Clock
  input wire logic ref_clk,
  // Host bus
  output logic [11:0] sa,
  output logic ior_n,
  output logic iow_n,
  output logic aen_n,
  output logic cs_n,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic buffer_direction_out
);
  initial begin
    sa = 12'h000;
    ior_n = 1'b1;
    iow_n = 1'b1;
    aen_n = 1'b1;
    cs_n = 1'b1;
    data_in = 8'h00;
  end

  // Returns {direction, enable, data} seen just before the strobe rises
  task automatic xfer(input logic rd, input logic [11:0] a, input logic [7:0] d,
                      input logic off, output logic [9:0] seen);
    @(negedge ref_clk);
    sa = a;
    aen_n = off;
    cs_n = off;
    if (!rd) data_in = d;
    // Data settles a cycle before the strobe falls
    @(negedge ref_clk);
    ior_n = !rd;
    iow_n = rd;
    repeat (10) @(negedge ref_clk);
    seen = {buffer_direction_out, data_oe, data_out};
    ior_n = 1'b1;
    iow_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    // Released lines do not keep their last value
    aen_n = 1'b1;
    cs_n = 1'b1;
    sa = ~a;
    data_in = ~data_in;
  endtask : xfer
endmodule : ipb_host_model

// >>> verification/isa_pnp_host_bus_port_tb.sv
/*
  Self-checking bench of the host bus port: Plug and Play, then ISA-PC, then processor mode.
  Assumes the host model of ipb_host_model.sv and a core stand-in kept here.
*/
`timescale 1ns/1ps
module isa_pnp_host_bus_port_tb;
  logic ref_clk, rst_n, ale, mode_open, mode_level, pnp_key_seen;
  logic ior_n, iow_n, aen_n, cs_n, data_oe, buffer_direction_out;
  logic aux_transfer_request, cfg_active, core_wr, core_rd, core_ctrl, core_aux;
  logic [11:0] sa;
  logic [7:0] data_in, data_out, core_addr, core_wdata, core_rdata;
  logic [3:0] io_window_straps, cfg_irq_line;
  logic [1:0] aux_transfer_ack_n;
  logic [7:0] core_store, last_addr, last_wdata;
  logic last_ctrl, last_aux;
  logic [15:0] wr_count, n0;
  int bad_count, check_count, n;

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  ipb_host_port u_ipb_host_port (.ref_clk(ref_clk), .rst_n(rst_n), .sa(sa), .ior_n(ior_n),
    .iow_n(iow_n), .aen_n(aen_n), .cs_n(cs_n), .ale(ale), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .buffer_direction_out(buffer_direction_out),
    .mode_open(mode_open), .mode_level(mode_level), .io_window_straps(io_window_straps),
    .aux_transfer_ack_n(aux_transfer_ack_n), .aux_transfer_request(aux_transfer_request),
    .pnp_key_seen(pnp_key_seen), .cfg_active(cfg_active), .cfg_irq_line(cfg_irq_line),
    .core_addr(core_addr), .core_wdata(core_wdata), .core_wr(core_wr), .core_rd(core_rd),
    .core_ctrl(core_ctrl), .core_aux(core_aux), .core_rdata(core_rdata));

  ipb_host_model u_ipb_host_model (.ref_clk(ref_clk), .sa(sa), .ior_n(ior_n),
    .iow_n(iow_n), .aen_n(aen_n), .cs_n(cs_n), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .buffer_direction_out(buffer_direction_out));

  // Core stand-in: read data depends on address so a wrong address shows
  assign core_rdata = core_store ^ core_addr;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_count <= 16'h0000;
      core_store <= 8'h00;
    end else if (core_wr) begin
      wr_count <= wr_count + 16'h0001;
      core_store <= core_wdata;
      last_addr <= core_addr;
      last_wdata <= core_wdata;
      last_ctrl <= core_ctrl;
      last_aux <= core_aux;
    end
  end

  task automatic results();
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : cyc

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic off);
    logic [9:0] s;
    u_ipb_host_model.xfer(1'b0, a, d, off, s);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [9:0] e);
    logic [9:0] s;
    u_ipb_host_model.xfer(1'b1, a, 8'h00, 1'b0, s);
    chk({6'h00, s}, {6'h00, e});
  endtask : rd

  task automatic cfg_wr(input logic [7:0] i, input logic [7:0] v);
    wr(12'h0279, i, 1'b0);
    wr(12'h0A79, v, 1'b0);
  endtask : cfg_wr

  // Read port sits at 0x203 once register 00h holds 80h
  task automatic cfg_rd(input logic [7:0] i, input logic [7:0] e);
    wr(12'h0279, i, 1'b0);
    rd(12'h0203, {2'b01, e});
  endtask : cfg_rd

  // Straps and ale stay put from reset on; ale high only for mode 2
  task automatic rst(input logic open, input logic lvl, input logic [3:0] st);
    @(negedge ref_clk);
    rst_n = 1'b0;
    mode_open = open;
    mode_level = lvl;
    io_window_straps = st;
    ale = open & lvl;
    cyc(5);
    rst_n = 1'b1;
    cyc(10);
  endtask : rst

  initial begin
    #1_000_000;
    bad_count++;
    results();
  end

  initial begin
    logic [9:0] s;
    bad_count = 0;
    check_count = 0;
    rst_n = 1'b0;
    ale = 1'b0;
    mode_open = 1'b0;
    mode_level = 1'b1;
    io_window_straps = 4'h1;
    pnp_key_seen = 1'b0;
    aux_transfer_ack_n = 2'b11;
    rst(1'b0, 1'b1, 4'h1);
    chk({13'h0000, cfg_active, aux_transfer_request, buffer_direction_out}, 16'h0001);
    @(negedge ref_clk);
    pnp_key_seen = 1'b1;
    @(negedge ref_clk);
    pnp_key_seen = 1'b0;
    cfg_wr(8'h03, 8'h00);
    cfg_wr(8'h06, 8'h01);
    cfg_wr(8'h00, 8'h80);
    cfg_rd(8'h06, 8'h01);
    cfg_wr(8'h30, 8'hFF);
    cfg_rd(8'h30, 8'h01);
    chk({15'h0000, cfg_active}, 16'h0001);
    cfg_wr(8'h30, 8'h00);
    cfg_wr(8'h31, 8'hFF);
    cfg_rd(8'h31, 8'h03);
    cfg_wr(8'h60, 8'hA3);
    cfg_wr(8'h61, 8'h40);
    cfg_rd(8'h60, 8'hA3);
    cfg_rd(8'h61, 8'h40);
    cfg_wr(8'h70, 8'hA5);
    chk({12'h000, cfg_irq_line}, 16'h0005);
    cfg_wr(8'h71, 8'h03);
    chk({12'h000, cfg_irq_line}, 16'h0005);
    cfg_rd(8'h74, 8'h04);
    cfg_rd(8'h75, 8'h04);
    cfg_rd(8'h32, 8'h00);
    rd(12'h0340, {2'b01, 8'h55});
    rd(12'h0341, {2'b01, 8'h55});
    cfg_wr(8'h31, 8'h02);
    rd(12'h0340, {2'b01, 8'hAA});
    cfg_wr(8'h31, 8'h00);
    u_ipb_host_model.xfer(1'b1, 12'h0340, 8'h00, 1'b0, s);
    chk({14'h0000, s[9:8]}, 16'h0002);
    cfg_wr(8'h31, 8'h03);
    cfg_wr(8'h30, 8'h01);
    wr(12'h0340, 8'h3C, 1'b0);
    chk({7'h00, last_ctrl, last_wdata}, 16'h003C);
    wr(12'h0341, 8'h77, 1'b0);
    chk({7'h00, last_ctrl, last_wdata}, 16'h0177);
    rd(12'h0341, {2'b01, 8'h76});
    rd(12'h0340, {2'b01, 8'h77});
    n0 = wr_count;
    wr(12'h0B40, 8'h11, 1'b0);
    wr(12'h0342, 8'h11, 1'b0);
    wr(12'h0340, 8'h11, 1'b1);
    chk(wr_count, n0);
    cfg_wr(8'h03, 8'h00);
    cfg_wr(8'h30, 8'h00);
    cfg_wr(8'h03, 8'h01);
    cfg_rd(8'h30, 8'h01);
    chk({15'h0000, cfg_active}, 16'h0001);
    // ISA-PC mode: window at 0x240, ten address bits
    rst(1'b0, 1'b0, 4'h4);
    wr(12'h0641, 8'h5A, 1'b0);
    chk({7'h00, last_ctrl, last_wdata}, 16'h015A);
    rd(12'h0240, {2'b01, 8'h5A});
    // Processor mode 3: open mode pin, all straps low
    rst(1'b1, 1'b0, 4'h0);
    n = 0;
    while (aux_transfer_request !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    chk({15'h0000, n > 2480 && n < 2505}, 16'h0001);
    aux_transfer_ack_n = 2'b10;
    cyc(8);
    chk({15'h0000, aux_transfer_request}, 16'h0000);
    n0 = wr_count;
    u_ipb_host_model.xfer(1'b1, 12'h00FF, 8'h00, 1'b1, s);
    chk({8'(wr_count - n0), 6'h00, last_aux, |last_addr}, 16'h0102);
    aux_transfer_ack_n = 2'b11;
    wr(12'h0042, 8'h11, 1'b0);
    chk({8'h00, last_addr}, 16'h0042);
    rd(12'h00A5, {2'b01, 8'hB4});
    n0 = wr_count;
    wr(12'h0042, 8'h22, 1'b1);
    chk(wr_count, n0);
    // Mode 4: the latch pulse takes the address the model left on the bus
    ale = 1'b1;
    cyc(4);
    ale = 1'b0;
    cyc(4);
    wr(12'h0011, 8'h33, 1'b0);
    chk({8'h00, last_addr}, 16'h00BD);
    // Mode 2: latch high from reset; a write strobe alone is no access
    rst(1'b1, 1'b1, 4'h0);
    wr(12'h0042, 8'h22, 1'b0);
    rd(12'h00A5, {2'b01, 8'hA5});
    chk(wr_count, 16'h0000);
    results();
  end
endmodule : isa_pnp_host_bus_port_tb
